/* src/mscr_pkg.sv */
/*
  Constants for the motor start-up configuration register bank.
  Assumes a single 125 MHz clock domain and a 32-bit word-addressed bus.
*/
package mscr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Register indices; the slave port is word-addressed, so address = index
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_STARTUP_ONE  = 12'h085;
  localparam logic [ADDR_W-1:0] IDX_STARTUP_TWO  = 12'h086;
  localparam logic [ADDR_W-1:0] IDX_STARTUP_STAT = 12'h087;
  localparam logic [ADDR_W-1:0] ADR_STARTUP_ONE  = IDX_STARTUP_ONE;
  localparam logic [ADDR_W-1:0] ADR_STARTUP_TWO  = IDX_STARTUP_TWO;
  localparam logic [ADDR_W-1:0] ADR_STARTUP_STAT = IDX_STARTUP_STAT;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]        RST_STARTUP_ONE = 6'h00;
  localparam logic [DATA_W-1:0] RST_STARTUP_TWO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions of startup_config_one
  // ----------------------------------------------------------------
  localparam int unsigned ONE_W          = 6;
  localparam int unsigned POS_REPEAT_LO  = 4;
  localparam int unsigned POS_REPEAT_HI  = 5;
  localparam int unsigned POS_LIMIT_SRC  = 3;
  localparam int unsigned POS_RAMPDOWN   = 2;
  localparam int unsigned POS_ACT_BRAKE  = 1;
  localparam int unsigned POS_REV_PROF   = 0;

  // ----------------------------------------------------------------
  // Field positions of startup_config_two
  // ----------------------------------------------------------------
  localparam int unsigned POS_OL_CAP_LO  = 27;
  localparam int unsigned POS_OL_CAP_HI  = 30;
  localparam int unsigned POS_A1_LO      = 23;
  localparam int unsigned POS_A1_HI      = 26;
  localparam int unsigned POS_A2_LO      = 19;
  localparam int unsigned POS_A2_HI      = 22;

  // ----------------------------------------------------------------
  // Field positions of the status word
  // ----------------------------------------------------------------
  localparam int unsigned POS_ST_CAP_LO  = 0;
  localparam int unsigned POS_ST_CAP_HI  = 3;
  localparam int unsigned POS_ST_A1_LO   = 4;
  localparam int unsigned POS_ST_A1_HI   = 7;
  localparam int unsigned POS_ST_A2_LO   = 8;
  localparam int unsigned POS_ST_A2_HI   = 11;
  localparam int unsigned POS_ST_CNT_LO  = 12;
  localparam int unsigned POS_ST_CNT_HI  = 14;
  localparam int unsigned POS_ST_RSVD    = 15;

  // Highest legal open-loop current code; Eh and Fh are reserved
  localparam logic [3:0] CAP_CODE_MAX = 4'hd;

endpackage

/* src/mscr_startup_regs.sv */
/*
  Start-up configuration register bank with an Avalon-MM slave port.
  Holds the probe, limit-source, ramp-down, braking and reverse-drive
  controls plus the second start-up word, and drives the resolved
  settings to the start-up sequencer. Assumes the sequencer and the
  general current setting live on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module mscr_startup_regs
  import mscr_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic [mscr_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [mscr_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [mscr_pkg::DATA_W-1:0] avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic [3:0]                 generalCurrentCap,
  input  wire logic                       reverseDriveActive,
  input  wire logic [3:0]                 revOpenLoopCurrent,
  input  wire logic [3:0]                 revAccelLinearCoef,
  input  wire logic [3:0]                 revAccelQuadCoef,
  output logic      [2:0]                 probeRunCount,
  output logic                            probeAverageOn,
  output logic      [3:0]                 openLoopCurrentCap,
  output logic      [3:0]                 accelLinearCoef,
  output logic      [3:0]                 accelQuadCoef,
  output logic                            torqueRampdownOn,
  output logic                            activeBrakeOn
);

  // ----------------------------------------------------------------
  // Storage and bus state
  // ----------------------------------------------------------------
  logic [ONE_W-1:0]  cfgOne_r;
  logic [DATA_W-1:0] cfgTwo_r;
  logic              waitReq_r;
  logic [DATA_W-1:0] readData_r;
  logic              reservedCap_r;
  logic              request;
  logic              accept;
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] readMux;

  // Byte-lane merge of write data into an old word
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] oldVal,
                                                    input logic [DATA_W-1:0] newVal,
                                                    input logic [3:0]        lanes);
    logic [DATA_W-1:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Lane merge and status layout assume one word of four byte lanes
  if (DATA_W != 32) begin : g_width_check
    $error("start-up register bank needs a 32-bit data word");
  end
  // Register map needs room for the highest word address
  if (ADDR_W < 8) begin : g_addr_check
    $error("start-up register bank needs at least 8 address bits");
  end
  // Stored control bits must cover every field of the first word
  if (ONE_W <= POS_REPEAT_HI) begin : g_one_check
    $error("first start-up word narrower than its fields");
  end
  // Open-loop cap field must sit inside the second word
  if (POS_OL_CAP_HI >= DATA_W) begin : g_two_check
    $error("open-loop cap field outside the second word");
  end

  // ----------------------------------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------------------------------
  // One wait state: request seen, answer next cycle with waitrequest low
  // A request withdrawn during its wait state is simply dropped
  assign request = (avs_read || avs_write) && waitReq_r;
  assign accept  = (avs_read || avs_write) && !waitReq_r;

  // Wait-request sequencing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitReq_r <= 1'b1;
    end else if (request) begin
      waitReq_r <= 1'b0;
    end else begin
      waitReq_r <= 1'b1;
    end
  end

  // Status word showing the resolved settings
  always_comb begin
    statusWord = '0;
    statusWord[POS_ST_CAP_HI:POS_ST_CAP_LO] = openLoopCurrentCap;
    statusWord[POS_ST_A1_HI:POS_ST_A1_LO]   = accelLinearCoef;
    statusWord[POS_ST_A2_HI:POS_ST_A2_LO]   = accelQuadCoef;
    statusWord[POS_ST_CNT_HI:POS_ST_CNT_LO] = probeRunCount;
    statusWord[POS_ST_RSVD]                 = reservedCap_r;
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    readMux = '0;
    unique case (avs_address)
      ADR_STARTUP_ONE:  readMux[ONE_W-1:0] = cfgOne_r;
      ADR_STARTUP_TWO:  readMux = cfgTwo_r;
      ADR_STARTUP_STAT: readMux = statusWord;
      default:          readMux = '0;
    endcase
  end

  // Read data captured when the answer is prepared
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      readData_r <= '0;
    end else if (request && avs_read) begin
      readData_r <= readMux;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // First start-up word, low control bits only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgOne_r <= RST_STARTUP_ONE;
    end else if (accept && avs_write && avs_address == ADR_STARTUP_ONE && avs_byteenable[0]) begin
      cfgOne_r <= avs_writedata[ONE_W-1:0];
    end
  end

  // Second start-up word, every bit read-write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgTwo_r <= RST_STARTUP_TWO;
    end else if (accept && avs_write && avs_address == ADR_STARTUP_TWO) begin
      cfgTwo_r <= merge_lanes(cfgTwo_r, avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------
  // Resolved settings to the sequencer
  // ----------------------------------------------------------------
  // Probe repetition and averaging
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      probeRunCount  <= 3'h1;
      probeAverageOn <= 1'b0;
    end else begin
      probeRunCount  <= {1'b0, cfgOne_r[POS_REPEAT_HI:POS_REPEAT_LO]} + 3'h1;
      probeAverageOn <= cfgOne_r[POS_REPEAT_HI:POS_REPEAT_LO] != 2'h0;
    end
  end

  // Open-loop cap: reverse-drive profile first, then source select
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      openLoopCurrentCap <= 4'h0;
      reservedCap_r      <= 1'b0;
    end else if (reverseDriveActive && cfgOne_r[POS_REV_PROF]) begin
      openLoopCurrentCap <= revOpenLoopCurrent;
      reservedCap_r      <= 1'b0;
    end else if (cfgOne_r[POS_LIMIT_SRC]) begin
      openLoopCurrentCap <= generalCurrentCap;
      reservedCap_r      <= 1'b0;
    end else begin
      openLoopCurrentCap <= cfgTwo_r[POS_OL_CAP_HI:POS_OL_CAP_LO];
      reservedCap_r      <= cfgTwo_r[POS_OL_CAP_HI:POS_OL_CAP_LO] > CAP_CODE_MAX;
    end
  end

  // Acceleration coefficients, forward or reverse profile
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      accelLinearCoef <= 4'h0;
      accelQuadCoef   <= 4'h0;
    end else if (reverseDriveActive && cfgOne_r[POS_REV_PROF]) begin
      accelLinearCoef <= revAccelLinearCoef;
      accelQuadCoef   <= revAccelQuadCoef;
    end else begin
      accelLinearCoef <= cfgTwo_r[POS_A1_HI:POS_A1_LO];
      accelQuadCoef   <= cfgTwo_r[POS_A2_HI:POS_A2_LO];
    end
  end

  // Ramp-down and braking enables
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      torqueRampdownOn <= 1'b0;
      activeBrakeOn    <= 1'b0;
    end else begin
      torqueRampdownOn <= cfgOne_r[POS_RAMPDOWN];
      activeBrakeOn    <= cfgOne_r[POS_ACT_BRAKE];
    end
  end

  // Bus outputs straight from their flip-flops
  assign avs_waitrequest = waitReq_r;
  assign avs_readdata    = readData_r;

endmodule

`default_nettype wire

/* bench/mscr_startup_regs_properties.sv */
/* Concurrent checks for the start-up register bank.
   Sees only the top module's ports; bound in below. */
`timescale 1ns/1ps
`default_nettype none
module mscr_startup_chk
  import mscr_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        reset_n,
  input wire logic [mscr_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [mscr_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0]                  avs_byteenable,
  input wire logic [mscr_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic [3:0]                  generalCurrentCap,
  input wire logic                        reverseDriveActive,
  input wire logic [3:0]                  revOpenLoopCurrent,
  input wire logic [3:0]                  revAccelLinearCoef,
  input wire logic [3:0]                  revAccelQuadCoef,
  input wire logic [2:0]                  probeRunCount,
  input wire logic                        probeAverageOn,
  input wire logic [3:0]                  openLoopCurrentCap,
  input wire logic [3:0]                  accelLinearCoef,
  input wire logic [3:0]                  accelQuadCoef,
  input wire logic                        torqueRampdownOn,
  input wire logic                        activeBrakeOn
);
  // ----------------------------------------------------------------
  // Bus timing and field decode
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Finished write to the first word with its low lane on
  sequence wr1_s;
    avs_write && !avs_waitrequest && avs_address == ADR_STARTUP_ONE && avs_byteenable[0];
  endsequence
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  probe_runs_a: assert property (wr1_s |-> ##2
    probeRunCount == 3'($past(avs_writedata[5:4], 2)) + 3'h1
    && probeAverageOn == ($past(avs_writedata[5:4], 2) != 2'h0))
    else $error("probe run count wrong");
  ramp_follow_a: assert property (wr1_s |-> ##2 torqueRampdownOn == $past(avs_writedata[2], 2))
    else $error("ramp-down enable wrong");
  brake_follow_a: assert property (wr1_s |-> ##2 activeBrakeOn == $past(avs_writedata[1], 2))
    else $error("active brake enable wrong");
  cap_general_a: assert property (wr1_s ##0 (avs_writedata[3] && !avs_writedata[0])
    |-> ##2 openLoopCurrentCap == $past(generalCurrentCap))
    else $error("general cap not selected");
  rev_profile_a: assert property (wr1_s ##0 avs_writedata[0] ##2 $past(reverseDriveActive)
    |-> openLoopCurrentCap == $past(revOpenLoopCurrent) && accelLinearCoef == $past(revAccelLinearCoef)
    && accelQuadCoef == $past(revAccelQuadCoef))
    else $error("reverse profile not selected");
endmodule
bind mscr_startup_regs mscr_startup_chk chk_u (
  .ref_clk            (ref_clk),
  .reset_n            (reset_n),
  .avs_address        (avs_address),
  .avs_read           (avs_read),
  .avs_write          (avs_write),
  .avs_writedata      (avs_writedata),
  .avs_byteenable     (avs_byteenable),
  .avs_readdata       (avs_readdata),
  .avs_waitrequest    (avs_waitrequest),
  .generalCurrentCap  (generalCurrentCap),
  .reverseDriveActive (reverseDriveActive),
  .revOpenLoopCurrent (revOpenLoopCurrent),
  .revAccelLinearCoef (revAccelLinearCoef),
  .revAccelQuadCoef   (revAccelQuadCoef),
  .probeRunCount      (probeRunCount),
  .probeAverageOn     (probeAverageOn),
  .openLoopCurrentCap (openLoopCurrentCap),
  .accelLinearCoef    (accelLinearCoef),
  .accelQuadCoef      (accelQuadCoef),
  .torqueRampdownOn   (torqueRampdownOn),
  .activeBrakeOn      (activeBrakeOn)
);
`default_nettype wire

/* bench/mscr_startup_regs_tb_top.sv */
/* Self-checking bench for the start-up register bank.
   Drives the bus and sequencer inputs directly; no partner model. */
`timescale 1ns/1ps
`default_nettype none
module mscr_startup_regs_tb_top;
  import mscr_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, scoreboard and run control
  // ----------------------------------------------------------------
  logic              ref_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [DATA_W-1:0] avs_writedata = '0, avs_readdata;
  logic [3:0]        avs_byteenable = '0, generalCurrentCap = '0, revOpenLoopCurrent = '0;
  logic [3:0]        revAccelLinearCoef = '0, revAccelQuadCoef = '0;
  logic [3:0]        openLoopCurrentCap, accelLinearCoef, accelQuadCoef;
  logic              reverseDriveActive = 1'b0, avs_waitrequest, rv;
  logic              probeAverageOn, torqueRampdownOn, activeBrakeOn;
  logic [2:0]        probeRunCount;
  logic [31:0]       seed = 32'h7b86273b, one, two, expQ[$];
  int                fail_count = 0, cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  mscr_startup_regs dut_u (
    .ref_clk            (ref_clk),
    .reset_n            (reset_n),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .generalCurrentCap  (generalCurrentCap),
    .reverseDriveActive (reverseDriveActive),
    .revOpenLoopCurrent (revOpenLoopCurrent),
    .revAccelLinearCoef (revAccelLinearCoef),
    .revAccelQuadCoef   (revAccelQuadCoef),
    .probeRunCount      (probeRunCount),
    .probeAverageOn     (probeAverageOn),
    .openLoopCurrentCap (openLoopCurrentCap),
    .accelLinearCoef    (accelLinearCoef),
    .accelQuadCoef      (accelQuadCoef),
    .torqueRampdownOn   (torqueRampdownOn),
    .activeBrakeOn      (activeBrakeOn)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (expQ.size() != 0) fail_count++;
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One bus transfer; a read notes its expected data first
  task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    if (rd) expQ.push_back(d);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Read data compared against the oldest note
  always @(posedge ref_clk)
    if (avs_read && avs_waitrequest === 1'b0 && expQ.size() > 0)
      check(avs_readdata, expQ.pop_front(), "readdata");
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check(probeRunCount, 1, "runs");
    check({openLoopCurrentCap, accelLinearCoef, accelQuadCoef, activeBrakeOn}, 0, "outs");
    @(posedge ref_clk);
    bus(1, ADR_STARTUP_TWO, 32'h0, 4'hf);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      two = seed;
      two[30:27] = 4'(seed[3:0] % 14);
      one = {seed[31:6], 2'(i), seed[3:0]};
      {reverseDriveActive, generalCurrentCap, revOpenLoopCurrent, revAccelLinearCoef,
       revAccelQuadCoef} <= seed[28:12];
      bus(0, ADR_STARTUP_TWO, two, 4'hf);
      bus(0, ADR_STARTUP_ONE, one, 4'hf);
      #1;
      rv = reverseDriveActive && one[0];
      check(probeRunCount, 32'(one[5:4]) + 1, "runs");
      check(probeAverageOn, one[5:4] != 2'h0, "avg");
      check(torqueRampdownOn, one[2], "ramp");
      check(activeBrakeOn, one[1], "brake");
      check(openLoopCurrentCap, rv ? revOpenLoopCurrent : one[3] ? generalCurrentCap : two[30:27],
            "cap");
      check({accelLinearCoef, accelQuadCoef}, rv ? {revAccelLinearCoef, revAccelQuadCoef} :
            two[26:19], "coef");
      @(posedge ref_clk);
      bus(1, ADR_STARTUP_ONE, {26'h0, one[5:0]}, 4'hf);
      bus(1, ADR_STARTUP_TWO, two, 4'hf);
    end
    bus(0, ADR_STARTUP_TWO, 32'ha5a5a5a5, 4'h2);
    bus(1, ADR_STARTUP_TWO, {two[31:16], 8'ha5, two[7:0]}, 4'hf);
    bus(1, 12'h100, 32'h0, 4'hf);
    bus(0, ADR_STARTUP_ONE, 32'h3f, 4'he);
    bus(1, ADR_STARTUP_ONE, {26'h0, one[5:0]}, 4'hf);
    // Status word: reserved dedicated cap code passes through and is flagged
    bus(0, ADR_STARTUP_TWO, 32'h7d28_0000, 4'hf);
    bus(0, ADR_STARTUP_ONE, 32'h0000_0030, 4'hf);
    bus(1, ADR_STARTUP_STAT, 32'h0000_c5af, 4'hf);
    // Reset in mid-run returns both words and the outputs to reset values
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check(probeRunCount, 1, "runs after reset");
    check(openLoopCurrentCap, 0, "cap after reset");
    @(posedge ref_clk);
    bus(1, ADR_STARTUP_TWO, 32'h0, 4'hf);
    bus(1, ADR_STARTUP_ONE, 32'h0, 4'hf);
    wrap_up();
  end
endmodule
`default_nettype wire
